// ==== pkg/aesr_pkg.sv ====
// Constants and types shared by the cipher register interface
package aesr_pkg;
	localparam int ADDR_W = 12;
	localparam int KEY_BYTES = 32;
	localparam int DATA_BYTES = 16;
	localparam int KEY128_BASE = 16;

	localparam logic [7:0] CTL_IDX = 8'h78;
	localparam logic [7:0] ACC_IDX = 8'h79;
	localparam logic [7:0] PTR_IDX = 8'h7a;
	localparam logic [7:0] WIN_IDX = 8'h7b;
	localparam logic [7:0] STAT_IDX = 8'h7c;
	localparam logic [7:0] CLR_IDX = 8'h7d;
	localparam logic [7:0] EN_IDX = 8'h7e;

	localparam logic [7:0] CTL_RST = 8'h00;
	localparam logic [7:0] ACC_RST = 8'h02;

	localparam int CTL_IE_BIT = 7;
	localparam int CTL_FLAG_BIT = 6;
	localparam int CTL_INVERSE_KEY_AUTO_BIT = 5;
	localparam int CTL_KEYGEN_BIT = 4;
	localparam int CTL_KS_BIT = 3;
	localparam int CTL_ENC_BIT = 1;
	localparam int CTL_RUN_BIT = 0;

	localparam int ACC_XOR_BIT = 3;
	localparam int ACC_STEP_BIT = 2;
	localparam int ACC_AUTO_BIT = 1;
	localparam int ACC_KD_BIT = 0;

	localparam int IRQ_DONE_BIT = 0;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {ST_IDLE, ST_DERIVE, ST_CIPHER} aesr_state_t;

	// Request towards the round engine; key and data LSB first
	typedef struct packed {
		logic start;
		logic derive;
		logic encrypt;
		logic key256;
		logic [255:0] key;
		logic [127:0] data;
	} aesr_core_req_t;

	typedef struct packed {
		logic done;
		logic [255:0] key;
		logic [127:0] data;
	} aesr_core_rsp_t;
endpackage : aesr_pkg

// ==== logic/aesr_engine.sv ====
// Cipher engine register interface with AXI4-Lite slave and memories
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
module aesr_engine
	import aesr_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic global_irq_enable,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic irq,
	output aesr_core_req_t core_req,
	input wire aesr_core_rsp_t core_rsp
);

	logic [7:0] ctl_q;
	logic xor_q;
	logic auto_q;
	logic kd_q;
	logic [4:0] ptr_q;
	logic [7:0] kmem_q [KEY_BYTES];
	logic [7:0] dmem_q [DATA_BYTES];
	aesr_state_t state_q;
	logic req_start_q;
	logic req_derive_q;
	logic req_enc_q;
	logic enc_q;
	logic key256_q;
	logic keygen_q;
	logic stat_q;
	logic en_q;
	logic irq_q;

	logic aw_full_q;
	logic w_full_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic rvalid_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_q;

	logic do_wr;
	logic wr_ok;
	logic [7:0] wr_idx;
	logic [7:0] wb;
	logic wsel_ctl;
	logic wsel_acc;
	logic wsel_ptr;
	logic wsel_win;
	logic wsel_clr;
	logic wsel_en;
	logic idle;
	logic start;
	logic fin;
	logic derive_done;
	logic cipher_done;
	logic win_wr;
	logic step;
	logic [4:0] ptr_next;
	logic [7:0] window;
	logic [255:0] key_v;
	logic [127:0] data_v;

	function automatic logic idx_mapped(input logic [7:0] idx);
		idx_mapped = (idx >= CTL_IDX) && (idx <= EN_IDX);
	endfunction : idx_mapped

	// AXI4-Lite write channels: address and data taken in any order
	assign s_axi_awready = !aw_full_q && !bvalid_q;
	assign s_axi_wready = !w_full_q && !bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign do_wr = aw_full_q && w_full_q;
	assign wr_idx = aw_addr_q[9:2];
	assign wr_ok = (aw_addr_q[ADDR_W-1:10] == '0) && idx_mapped(wr_idx);
	assign wb = w_data_q[7:0];

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			aw_full_q <= 1'b0;
			aw_addr_q <= '0;
			w_full_q <= 1'b0;
			w_data_q <= '0;
			w_strb_q <= '0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_full_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			else if (do_wr)
				aw_full_q <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_full_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			else if (do_wr)
				w_full_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end
		else if (do_wr)
		begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready)
			bvalid_q <= 1'b0;
	end

	// Register strobes; only lane 0 carries register bits
	always_comb
	begin
		wsel_ctl = 1'b0;
		wsel_acc = 1'b0;
		wsel_ptr = 1'b0;
		wsel_win = 1'b0;
		wsel_clr = 1'b0;
		wsel_en = 1'b0;
		if (do_wr && wr_ok && w_strb_q[0])
		begin
			wsel_ctl = (wr_idx == CTL_IDX);
			wsel_acc = (wr_idx == ACC_IDX);
			wsel_ptr = (wr_idx == PTR_IDX);
			wsel_win = (wr_idx == WIN_IDX);
			wsel_clr = (wr_idx == CLR_IDX);
			wsel_en = (wr_idx == EN_IDX);
		end
	end

	assign idle = (state_q == ST_IDLE);
	assign start = wsel_ctl && wb[CTL_RUN_BIT] && idle && !ctl_q[CTL_RUN_BIT];
	assign derive_done = core_rsp.done && (state_q == ST_DERIVE);
	assign cipher_done = core_rsp.done && (state_q == ST_CIPHER);
	assign fin = cipher_done || (derive_done && keygen_q);

	// Control register; mode bits may change while busy, run uses
	// the values latched at start
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			ctl_q <= CTL_RST;
		else
		begin
			if (wsel_ctl)
			begin
				ctl_q[CTL_IE_BIT] <= wb[CTL_IE_BIT];
				ctl_q[CTL_INVERSE_KEY_AUTO_BIT] <= wb[CTL_INVERSE_KEY_AUTO_BIT];
				ctl_q[CTL_KEYGEN_BIT] <= wb[CTL_KEYGEN_BIT];
				ctl_q[CTL_KS_BIT] <= wb[CTL_KS_BIT];
				ctl_q[CTL_ENC_BIT] <= wb[CTL_ENC_BIT];
			end
			if (fin)
				ctl_q[CTL_FLAG_BIT] <= 1'b1;
			else if (wsel_ctl && !wb[CTL_FLAG_BIT])
				ctl_q[CTL_FLAG_BIT] <= 1'b0;
			if (fin)
				ctl_q[CTL_RUN_BIT] <= 1'b0;
			else if (start)
				ctl_q[CTL_RUN_BIT] <= 1'b1;
		end
	end

	// Run sequencer: key derivation alone, one block, or derivation then one block
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_q <= ST_IDLE;
			req_start_q <= 1'b0;
			req_derive_q <= 1'b0;
			req_enc_q <= 1'b0;
			enc_q <= 1'b0;
			key256_q <= 1'b0;
			keygen_q <= 1'b0;
		end
		else
		begin
			req_start_q <= 1'b0;
			unique case (state_q)
				ST_IDLE:
					if (start)
					begin
						req_start_q <= 1'b1;
						enc_q <= wb[CTL_ENC_BIT];
						key256_q <= wb[CTL_KS_BIT];
						keygen_q <= wb[CTL_KEYGEN_BIT];
						if (wb[CTL_KEYGEN_BIT])
						begin
							state_q <= ST_DERIVE;
							req_derive_q <= 1'b1;
							req_enc_q <= !wb[CTL_ENC_BIT];
						end
						else if (wb[CTL_INVERSE_KEY_AUTO_BIT])
						begin
							state_q <= ST_DERIVE;
							req_derive_q <= 1'b1;
							req_enc_q <= wb[CTL_ENC_BIT];
						end
						else
						begin
							state_q <= ST_CIPHER;
							req_derive_q <= 1'b0;
							req_enc_q <= wb[CTL_ENC_BIT];
						end
					end
				ST_DERIVE:
					if (core_rsp.done)
					begin
						if (keygen_q)
							state_q <= ST_IDLE;
						else
						begin
							state_q <= ST_CIPHER;
							req_start_q <= 1'b1;
							req_derive_q <= 1'b0;
							req_enc_q <= enc_q;
						end
					end
				ST_CIPHER:
					if (core_rsp.done)
						state_q <= ST_IDLE;
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// Access control; a step write leaves the mode bits alone
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			xor_q <= ACC_RST[ACC_XOR_BIT];
			auto_q <= ACC_RST[ACC_AUTO_BIT];
			kd_q <= ACC_RST[ACC_KD_BIT];
		end
		else if (wsel_acc && !wb[ACC_STEP_BIT])
		begin
			xor_q <= wb[ACC_XOR_BIT];
			auto_q <= wb[ACC_AUTO_BIT];
			kd_q <= wb[ACC_KD_BIT];
		end
	end

	assign win_wr = wsel_win && idle;
	assign step = (wsel_acc && wb[ACC_STEP_BIT]) || (win_wr && auto_q);
	assign ptr_next = kd_q ? {1'b0, ptr_q[3:0] + 4'h1} : ptr_q + 5'h01;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			ptr_q <= '0;
		else if (wsel_ptr)
			ptr_q <= wb[4:0];
		else if (step)
			ptr_q <= ptr_next;
	end

	// Window shows the key byte under the pointer, or the data byte under its low four bits
	assign window = kd_q ? dmem_q[ptr_q[3:0]] : kmem_q[ptr_q];

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (int i = 0; i < KEY_BYTES; i++)
				kmem_q[i] <= 8'h00;
		end
		else if (derive_done)
		begin
			for (int i = 0; i < KEY_BYTES; i++)
				if (key256_q)
					kmem_q[i] <= core_rsp.key[8*i +: 8];
				else if (i >= KEY128_BASE)
					kmem_q[i] <= core_rsp.key[8*(i-KEY128_BASE) +: 8];
		end
		else if (win_wr && !kd_q)
			kmem_q[ptr_q] <= wb;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (int i = 0; i < DATA_BYTES; i++)
				dmem_q[i] <= 8'h00;
		end
		else if (cipher_done)
		begin
			for (int i = 0; i < DATA_BYTES; i++)
				dmem_q[i] <= core_rsp.data[8*i +: 8];
		end
		else if (win_wr && kd_q)
			dmem_q[ptr_q[3:0]] <= xor_q ? (dmem_q[ptr_q[3:0]] ^ wb) : wb;
	end

	// Key and data handed over least significant byte first
	always_comb
	begin
		key_v = '0;
		data_v = '0;
		for (int i = 0; i < KEY_BYTES; i++)
			if (key256_q)
				key_v[8*i +: 8] = kmem_q[i];
			else if (i >= KEY128_BASE)
				key_v[8*(i-KEY128_BASE) +: 8] = kmem_q[i];
		for (int i = 0; i < DATA_BYTES; i++)
			data_v[8*i +: 8] = dmem_q[i];
	end

	always_comb
	begin
		core_req.start = req_start_q;
		core_req.derive = req_derive_q;
		core_req.encrypt = req_enc_q;
		core_req.key256 = key256_q;
		core_req.key = key_v;
		core_req.data = data_v;
	end

	// Sticky done status; a completion beats a clear in the same cycle
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			stat_q <= 1'b0;
			en_q <= 1'b0;
			irq_q <= 1'b0;
		end
		else
		begin
			if (fin)
				stat_q <= 1'b1;
			else if (wsel_clr && wb[IRQ_DONE_BIT])
				stat_q <= 1'b0;
			if (wsel_en)
				en_q <= wb[IRQ_DONE_BIT];
			irq_q <= global_irq_enable && ((ctl_q[CTL_IE_BIT] &&
				ctl_q[CTL_FLAG_BIT]) || (stat_q && en_q));
		end
	end

	assign irq = irq_q;

	// AXI4-Lite read channel
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= '0;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_q <= 1'b1;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
			if ((s_axi_araddr[ADDR_W-1:10] != '0) ||
				!idx_mapped(s_axi_araddr[9:2]))
				rresp_q <= RESP_SLVERR;
			else
				unique case (s_axi_araddr[9:2])
					CTL_IDX: rdata_q[7:0] <= ctl_q;
					ACC_IDX: rdata_q[7:0] <= {4'h0, xor_q, 1'b0, auto_q, kd_q};
					PTR_IDX: rdata_q[7:0] <= {3'h0, ptr_q};
					WIN_IDX: rdata_q[7:0] <= window;
					STAT_IDX: rdata_q[7:0] <= {7'h00, stat_q};
					EN_IDX: rdata_q[7:0] <= {7'h00, en_q};
					default: rdata_q[7:0] <= 8'h00;
				endcase
		end
		else if (s_axi_rready)
			rvalid_q <= 1'b0;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	flag_set_a: assert property (fin |=> ctl_q[CTL_FLAG_BIT]
		&& !ctl_q[CTL_RUN_BIT])
		else $error("done flag not set at completion");
	irq_gate_a: assert property ($rose(irq) |-> $past(global_irq_enable))
		else $error("interrupt without global enable");
	irq_fire_a: assert property ((ctl_q[CTL_IE_BIT] && ctl_q[CTL_FLAG_BIT]
		&& global_irq_enable) |=> irq)
		else $error("enabled completion gave no interrupt");
	busy_hold_a: assert property (!idle |-> ctl_q[CTL_RUN_BIT])
		else $error("run bit low while busy");
	inverse_key_auto_seq_a: assert property ((start && !wb[CTL_KEYGEN_BIT]
		&& wb[CTL_INVERSE_KEY_AUTO_BIT] && wb[CTL_ENC_BIT]) |=> core_req.start
		&& core_req.derive && core_req.encrypt)
		else $error("auto key run did not derive first");
	keygen_end_a: assert property ((derive_done && keygen_q)
		|=> idle && !cipher_done)
		else $error("key generation went on to data");
	keygen_dir_a: assert property ((start && wb[CTL_KEYGEN_BIT])
		|=> core_req.derive
		&& (core_req.encrypt == !$past(wb[CTL_ENC_BIT])))
		else $error("key generation direction wrong");
	enc_dir_a: assert property ((start && !wb[CTL_KEYGEN_BIT]
		&& !wb[CTL_INVERSE_KEY_AUTO_BIT]) |=> !core_req.derive
		&& (core_req.encrypt == $past(w_data_q[CTL_ENC_BIT])))
		else $error("cipher direction wrong");
	key_half_a: assert property (!key256_q |->
		(core_req.key[255:128] == '0) && (core_req.key[7:0] == kmem_q[16]))
		else $error("128-bit key layout wrong");
	step_wrap_a: assert property ((step && !kd_q && ptr_q == 5'h1f)
		|=> ptr_q == 5'h00)
		else $error("key pointer did not wrap");
	step_keep_a: assert property ((wsel_acc && wb[ACC_STEP_BIT])
		|=> $stable(xor_q) && $stable(auto_q) && $stable(kd_q))
		else $error("step write changed access bits");
	step_inc_a: assert property ((wsel_acc && wb[ACC_STEP_BIT] && kd_q)
		|=> ptr_q == {1'b0, $past(ptr_q[3:0]) + 4'h1})
		else $error("manual step did not advance");
	xor_win_a: assert property ((win_wr && kd_q && xor_q && !auto_q)
		|=> window == ($past(window) ^ $past(wb)))
		else $error("xor window write wrong");
	auto_step_a: assert property ((win_wr && auto_q && !kd_q
		&& ptr_q != 5'h1f) |=> ptr_q == $past(ptr_q) + 5'h01)
		else $error("auto step did not advance");

endmodule : aesr_engine

// ==== bench/testbench.sv ====
// Register-level testbench for the cipher engine register interface
`timescale 1ns/100ps
module testbench
	import aesr_pkg::*;
;
	logic clk, rst_b, gie;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	aesr_core_req_t req, last_req;
	aesr_core_rsp_t rsp;
	int fail_count, total_checks, cyc, starts;

	aesr_engine aesr_engine_inst (
		.clk(clk), .rst_b(rst_b), .global_irq_enable(gie),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq),
		.core_req(req), .core_rsp(rsp)
	);

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Captures every start pulse of the round engine request
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (req.start === 1'b1)
		begin
			last_req <= req;
			starts <= starts + 1;
		end
		if (cyc == 20000)
		begin
			fail_count++;
			give_verdict();
		end
	end

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Handshakes sampled at the rising edge, released right after it
	task automatic wr(input logic [7:0] idx, input logic [7:0] v,
		output logic [1:0] rs);
		logic b;
		b = 1'b0;
		@(posedge clk);
		awaddr <= {2'b00, idx, 2'b00};
		wdata <= {24'h0, v};
		wstrb <= 4'h1;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b)
		begin
			@(posedge clk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			b = bvalid;
			rs = bresp;
		end
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] idx, output logic [31:0] v,
		output logic [1:0] rs);
		logic b;
		b = 1'b0;
		@(posedge clk);
		araddr <= {2'b00, idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!b)
		begin
			@(posedge clk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			b = rvalid;
			v = rdata;
			rs = rresp;
		end
		rready <= 1'b0;
	endtask : rd

	task automatic wo(input logic [7:0] idx, input logic [7:0] v);
		logic [1:0] rs;
		wr(idx, v, rs);
	endtask : wo

	task automatic rc(input logic [7:0] idx, input logic [7:0] e);
		logic [31:0] v;
		logic [1:0] rs;
		rd(idx, v, rs);
		chk(v, {24'h0, e});
	endtask : rc

	task automatic irq_is(input logic e);
		repeat (2) @(posedge clk);
		#1;
		chk(32'(irq), 32'(e));
	endtask : irq_is

	// Waits for start number n, then answers with a done pulse
	task automatic finish(input int n, input logic [255:0] k,
		input logic [127:0] dt);
		while (starts < n)
			@(posedge clk);
		repeat (3) @(posedge clk);
		rsp <= '{1'b1, k, dt};
		@(posedge clk);
		rsp.done <= 1'b0;
	endtask : finish

	initial
	begin
		rst_b = 1'b0;
		gie = 1'b0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		wstrb = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		rsp = '0;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		gie <= 1'b1;
		rc(CTL_IDX, CTL_RST);
		rc(ACC_IDX, ACC_RST);
		// Key memory, auto step, wrap past byte 31
		wo(PTR_IDX, 8'h1f);
		wo(WIN_IDX, 8'ha5);
		wo(WIN_IDX, 8'h3c);
		rc(PTR_IDX, 8'h01);
		wo(PTR_IDX, 8'h1f);
		rc(WIN_IDX, 8'ha5);
		wo(ACC_IDX, 8'h08);
		wo(PTR_IDX, 8'h00);
		wo(WIN_IDX, 8'h0f);
		rc(WIN_IDX, 8'h0f);
		// Data memory with xor, wrap past byte 15
		wo(ACC_IDX, 8'h0b);
		wo(PTR_IDX, 8'h0f);
		wo(WIN_IDX, 8'h55);
		rc(PTR_IDX, 8'h00);
		wo(PTR_IDX, 8'h0f);
		wo(ACC_IDX, 8'h09);
		wo(WIN_IDX, 8'hff);
		rc(WIN_IDX, 8'haa);
		wo(ACC_IDX, 8'h04);
		rc(ACC_IDX, 8'h09);
		rc(PTR_IDX, 8'h00);
		wr(8'h7f, 8'h01, r);
		chk(32'(r), 32'(RESP_SLVERR));
		rd(8'h10, d, r);
		chk(d, 32'h0);
		chk(32'(r), 32'(RESP_SLVERR));
		// Encrypt run, 256-bit key, interrupt enabled
		wo(CTL_IDX, 8'h8b);
		rc(CTL_IDX, 8'h8b);
		finish(1, '0, 128'h00112233445566778899aabbccddeeff);
		chk(32'({last_req.derive, last_req.encrypt, last_req.key256}), 3);
		chk(32'(last_req.data[127:120]), 32'haa);
		rc(CTL_IDX, 8'hca);
		irq_is(1'b1);
		wo(PTR_IDX, 8'h00);
		rc(WIN_IDX, 8'hff);
		wo(PTR_IDX, 8'h0f);
		rc(WIN_IDX, 8'h00);
		@(posedge clk);
		gie <= 1'b0;
		irq_is(1'b0);
		@(posedge clk);
		gie <= 1'b1;
		wo(CTL_IDX, 8'h00);
		rc(CTL_IDX, 8'h00);
		irq_is(1'b0);
		// Key-only generation, 128-bit, decrypt direction
		wo(ACC_IDX, 8'h00);
		wo(PTR_IDX, 8'h10);
		wo(WIN_IDX, 8'h5a);
		wo(ACC_IDX, 8'h01);
		wo(PTR_IDX, 8'h05);
		wo(WIN_IDX, 8'h44);
		wo(CTL_IDX, 8'h11);
		finish(2, {128'h0, 128'h0f0e0d0c0b0a09080706050403020100}, '1);
		chk(32'({last_req.derive, last_req.encrypt, last_req.key256}), 6);
		chk(32'(last_req.key[7:0]), 32'h5a);
		rc(CTL_IDX, 8'h50);
		irq_is(1'b0);
		rc(WIN_IDX, 8'h44);
		wo(ACC_IDX, 8'h00);
		wo(PTR_IDX, 8'h11);
		rc(WIN_IDX, 8'h01);
		// Automatic inverse key, then encrypt
		wo(CTL_IDX, 8'h23);
		finish(3, {128'h0, {16{8'h77}}}, '0);
		chk(32'({last_req.derive, last_req.encrypt}), 3);
		finish(4, '0, {16{8'h66}});
		chk(32'(last_req.derive), 0);
		rc(CTL_IDX, 8'h62);
		wo(PTR_IDX, 8'h10);
		rc(WIN_IDX, 8'h77);
		// Status, enable and clear path
		rc(STAT_IDX, 8'h01);
		wo(EN_IDX, 8'h01);
		irq_is(1'b1);
		wo(CLR_IDX, 8'h01);
		irq_is(1'b0);
		rc(STAT_IDX, 8'h00);
		give_verdict();
	end
endmodule : testbench
